// ### core/t1_alarm_status_interrupt.sv
`timescale 1ns/1ps
module t1_alarm_status_interrupt #(
  parameter logic [2:0] framer_num = 3'h0,
  parameter int clk_mhz = 50,
  parameter int bit_khz = 1544,
  parameter int ais_window_bits = alarm_pkg::ais_window_us * bit_khz / 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_frame_loss_now,
  input wire logic chan_bit2_valid,
  input wire logic chan_bit2,
  input wire logic fbit12_valid,
  input wire logic fbit12,
  input wire logic fdl_word_valid,
  input wire logic [15:0] fdl_word,
  output logic irq_out_n
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [7:0] rx_latched_status_1_r, rx_irq_mask_1_r, rx_line_control_2_r, live_r;
  logic [7:0] rx_latched_status_1_nxt;
  logic [15:0] base_w;
  logic [15:0] rel_w;
  logic [8:0] idx_w;
  logic in_framer_w;
  logic acc_w, wr_w, rd_w;
  logic hit_rx_latched_status_1_w, hit_rx_irq_mask_1_w, hit_ctl_w, hit_live1_w, hit_zero_w;
  logic mapped_w;
  logic [7:0] rd_byte_w;
  // framer base from the stride
  assign base_w = 16'(framer_num) * 16'(alarm_pkg::framer_stride) * 16'h4;
  assign rel_w = paddr - base_w;
  assign in_framer_w = (paddr >= base_w) && (rel_w < 16'h0800)
                       && (paddr[1:0] == 2'h0);
  assign idx_w = rel_w[10:2];
  assign acc_w = psel && penable && in_framer_w;
  assign wr_w = acc_w && pwrite && pstrb[0];
  assign rd_w = acc_w && !pwrite;
  assign hit_rx_latched_status_1_w = (idx_w == alarm_pkg::ofs_rx_latched_status_1);
  assign hit_rx_irq_mask_1_w = (idx_w == alarm_pkg::ofs_rx_irq_mask_1);
  assign hit_ctl_w = (idx_w == alarm_pkg::ofs_rx_ctl2);
  assign hit_live1_w = (idx_w == alarm_pkg::ofs_live1);
  // listed registers outside this block read zero
  assign hit_zero_w = (idx_w == alarm_pkg::ofs_lcv_hi)
    || (idx_w == alarm_pkg::ofs_lcv_lo) || (idx_w == alarm_pkg::ofs_pcv_hi)
    || (idx_w == alarm_pkg::ofs_pcv_lo) || (idx_w == alarm_pkg::ofs_fos_hi)
    || (idx_w == alarm_pkg::ofs_fos_lo) || (idx_w == alarm_pkg::ofs_ebe_hi)
    || (idx_w == alarm_pkg::ofs_ebe_lo) || (idx_w == alarm_pkg::ofs_ts_mon)
    || (idx_w == alarm_pkg::ofs_err_cfg) || (idx_w == alarm_pkg::ofs_rx_latched_status_2)
    || (idx_w == alarm_pkg::ofs_rx_latched_status_3) || (idx_w == alarm_pkg::ofs_rx_latched_status_7)
    || (idx_w == alarm_pkg::ofs_rx_irq_mask_3) || (idx_w == alarm_pkg::ofs_rx_irq_mask_4)
    || (idx_w == alarm_pkg::ofs_rx_irq_mask_7) || (idx_w == alarm_pkg::ofs_live3)
    || (idx_w == alarm_pkg::ofs_tx_latched_status_1) || (idx_w == alarm_pkg::ofs_tx_sync_latched_status);
  assign mapped_w = hit_rx_latched_status_1_w || hit_rx_irq_mask_1_w || hit_ctl_w || hit_live1_w
                    || hit_zero_w;

  // read mux; live byte is a register so it cannot move mid-read
  always_comb begin
    if (hit_rx_latched_status_1_w) begin
      rd_byte_w = rx_latched_status_1_r;
    end else if (hit_rx_irq_mask_1_w) begin
      rd_byte_w = rx_irq_mask_1_r;
    end else if (hit_ctl_w) begin
      rd_byte_w = rx_line_control_2_r;
    end else if (hit_live1_w) begin
      rd_byte_w = live_r;
    end else begin
      rd_byte_w = alarm_pkg::reset_byte;
    end
  end

  // zero-wait answer, error on unmapped index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(in_framer_w && mapped_w);
      prdata <= (psel && !penable && !pwrite) ? {24'h0, rd_byte_w} : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_mask_1_r <= alarm_pkg::reset_byte;
      rx_line_control_2_r <= alarm_pkg::reset_byte;
    end else begin
      if (wr_w && hit_rx_irq_mask_1_w) rx_irq_mask_1_r <= pwdata[7:0];
      if (wr_w && hit_ctl_w) rx_line_control_2_r <= pwdata[7:0];
    end
  end

  logic f12_mode_w, esf_mode_w;
  assign f12_mode_w = rx_line_control_2_r[alarm_pkg::bit_f12_mode];
  assign esf_mode_w = rx_line_control_2_r[alarm_pkg::bit_esf_mode];

  // ---------------------------------------------------------------
  // blue alarm: zeros counted in a fixed window of line bits
  // ---------------------------------------------------------------
  logic [15:0] ais_pos_r;
  logic [3:0] ais_zeros_r;
  logic ais_r;
  logic ais_end_w;
  logic [3:0] ais_zsum_w;
  assign ais_end_w = rx_bit_valid
                     && (ais_pos_r == 16'(ais_window_bits - 1));
  assign ais_zsum_w = ais_zeros_r + {3'h0, !rx_bit};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ais_pos_r <= 16'h0;
      ais_zeros_r <= 4'h0;
      ais_r <= 1'b0;
    end else if (rx_bit_valid) begin
      ais_pos_r <= ais_end_w ? 16'h0 : ais_pos_r + 16'h1;
      if (ais_end_w) begin
        ais_zeros_r <= 4'h0;
        ais_r <= (ais_zsum_w <= 4'(alarm_pkg::ais_set_zeros));
      end else if (ais_zeros_r < 4'(alarm_pkg::ais_clr_zeros)) begin
        ais_zeros_r <= ais_zsum_w; // saturates, only the threshold matters
      end
    end
  end

  // ---------------------------------------------------------------
  // loss of signal
  // ---------------------------------------------------------------
  logic [7:0] los_zrun_r, los_span_r, los_ones_r;
  logic los_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_zrun_r <= 8'h0;
      los_span_r <= 8'h0;
      los_ones_r <= 8'h0;
      los_r <= 1'b0;
    end else if (rx_bit_valid) begin
      los_zrun_r <= rx_bit ? 8'h0 : ((los_zrun_r == 8'hff) ? los_zrun_r
                                     : los_zrun_r + 8'h1);
      if (!los_r) begin
        los_span_r <= 8'h0;
        los_ones_r <= 8'h0;
        if (!rx_bit && los_zrun_r == 8'(alarm_pkg::los_zero_run - 1))
          los_r <= 1'b1;
      end else if (los_span_r == 8'h0) begin
        if (rx_bit) begin
          los_span_r <= 8'h1; // window opens at first one
          los_ones_r <= 8'h1;
        end
      end else begin
        if (los_ones_r + {7'h0, rx_bit} >= 8'(alarm_pkg::los_one_need)) begin
          los_r <= 1'b0;
        end else if (los_span_r == 8'(alarm_pkg::los_one_span - 1)) begin
          los_span_r <= 8'h0;
          los_ones_r <= 8'h0;
        end else begin
          los_span_r <= los_span_r + 8'h1;
          los_ones_r <= los_ones_r + {7'h0, rx_bit};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // yellow alarm, three modes
  // ---------------------------------------------------------------
  logic [8:0] ch_cnt_r, ch_zero_r;
  logic rai_b2_r;
  logic [1:0] f12_hist_r;
  logic rai_f12_r;
  logic [4:0] fdl_cnt_r, fdl_hit_r;
  logic rai_esf_r;
  logic ch_end_w, fdl_end_w, fdl_match_w;
  logic [8:0] ch_zsum_w;
  logic [4:0] fdl_hsum_w;
  assign ch_end_w = ch_cnt_r == 9'(alarm_pkg::rai_chan_span - 1);
  assign ch_zsum_w = ch_zero_r + {8'h0, !chan_bit2};
  assign fdl_match_w = (fdl_word == alarm_pkg::fdl_yellow);
  assign fdl_end_w = fdl_cnt_r == 5'(alarm_pkg::fdl_span - 1);
  assign fdl_hsum_w = fdl_hit_r + {4'h0, fdl_match_w};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_cnt_r <= 9'h0;
      ch_zero_r <= 9'h0;
      rai_b2_r <= 1'b0;
      f12_hist_r <= 2'h0;
      rai_f12_r <= 1'b0;
      fdl_cnt_r <= 5'h0;
      fdl_hit_r <= 5'h0;
      rai_esf_r <= 1'b0;
    end else begin
      if (chan_bit2_valid) begin
        ch_cnt_r <= ch_end_w ? 9'h0 : ch_cnt_r + 9'h1;
        ch_zero_r <= ch_end_w ? 9'h0 : ch_zsum_w;
        if (ch_end_w)
          rai_b2_r <= (ch_zsum_w >= 9'(alarm_pkg::rai_chan_set));
      end
      if (fbit12_valid) begin
        f12_hist_r <= {f12_hist_r[0], fbit12};
        if (f12_hist_r[0] && fbit12) rai_f12_r <= 1'b1;
        if (!f12_hist_r[0] && !fbit12) rai_f12_r <= 1'b0;
      end
      if (fdl_word_valid) begin
        // all 16 words of a window matching sets; windows of 16 decide clearing
        fdl_cnt_r <= fdl_end_w ? 5'h0 : fdl_cnt_r + 5'h1;
        fdl_hit_r <= fdl_end_w ? 5'h0 : fdl_hsum_w;
        if (fdl_end_w && fdl_hsum_w == 5'(alarm_pkg::fdl_span))
          rai_esf_r <= 1'b1;
        else if (fdl_end_w && fdl_hsum_w <= 5'(alarm_pkg::fdl_clr_max))
          rai_esf_r <= 1'b0;
      end
    end
  end

  logic rai_w;
  assign rai_w = esf_mode_w ? rai_esf_r : (f12_mode_w ? rai_f12_r : rai_b2_r);

  // ---------------------------------------------------------------
  // live status, held while a transfer is in progress
  // ---------------------------------------------------------------
  logic [7:0] live_nxt;
  assign live_nxt = {4'h0, rai_w, ais_r, los_r, rx_frame_loss_now};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_r <= alarm_pkg::reset_byte;
    end else if (!psel) begin
      live_r <= live_nxt;
    end
  end

  // ---------------------------------------------------------------
  // latched status: edges of live bits, write one to clear
  // ---------------------------------------------------------------
  logic [7:0] prev_r;
  logic [7:0] rise_w, fall_w, set_w, clr_w;
  assign rise_w = live_r & ~prev_r;
  assign fall_w = ~live_r & prev_r;
  assign set_w = {fall_w[3:0], rise_w[3:0]};
  assign clr_w = (wr_w && hit_rx_latched_status_1_w) ? pwdata[7:0] : 8'h00;
  // set wins over a clear in the same cycle
  assign rx_latched_status_1_nxt = (rx_latched_status_1_r & ~clr_w) | set_w;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= alarm_pkg::reset_byte;
      rx_latched_status_1_r <= alarm_pkg::reset_byte;
    end else begin
      prev_r <= live_r;
      rx_latched_status_1_r <= rx_latched_status_1_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt, active low
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(rx_latched_status_1_r & rx_irq_mask_1_r);
    end
  end

endmodule : t1_alarm_status_interrupt

// ### pkg/alarm_pkg.sv
package alarm_pkg;

  // ---------------------------------------------------------------
  // register offsets, framer one, byte indices (index x4 = address)
  // ---------------------------------------------------------------
  localparam logic [11:0] framer_stride = 12'h200;
  localparam logic [8:0] ofs_lcv_hi = 9'h050;
  localparam logic [8:0] ofs_lcv_lo = 9'h051;
  localparam logic [8:0] ofs_pcv_hi = 9'h052;
  localparam logic [8:0] ofs_pcv_lo = 9'h053;
  localparam logic [8:0] ofs_fos_hi = 9'h054;
  localparam logic [8:0] ofs_fos_lo = 9'h055;
  localparam logic [8:0] ofs_ebe_hi = 9'h056;
  localparam logic [8:0] ofs_ebe_lo = 9'h057;
  localparam logic [8:0] ofs_ts_mon = 9'h060;
  localparam logic [8:0] ofs_err_cfg = 9'h086;
  localparam logic [8:0] ofs_rx_latched_status_1 = 9'h090;
  localparam logic [8:0] ofs_rx_latched_status_2 = 9'h091;
  localparam logic [8:0] ofs_rx_latched_status_3 = 9'h092;
  localparam logic [8:0] ofs_rx_latched_status_7 = 9'h096;
  localparam logic [8:0] ofs_rx_irq_mask_1 = 9'h0a0;
  localparam logic [8:0] ofs_rx_irq_mask_3 = 9'h0a2;
  localparam logic [8:0] ofs_rx_irq_mask_4 = 9'h0a3;
  localparam logic [8:0] ofs_rx_irq_mask_7 = 9'h0a6;
  localparam logic [8:0] ofs_live1 = 9'h0b0;
  localparam logic [8:0] ofs_live3 = 9'h0b2;
  localparam logic [8:0] ofs_rx_ctl2 = 9'h0b8;
  localparam logic [8:0] ofs_tx_latched_status_1 = 9'h190;
  localparam logic [8:0] ofs_tx_sync_latched_status = 9'h192;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int bit_lof = 0;
  localparam int bit_los = 1;
  localparam int bit_ais = 2;
  localparam int bit_rai = 3;
  localparam int bit_lof_clr = 4;
  localparam int bit_los_clr = 5;
  localparam int bit_ais_clr = 6;
  localparam int bit_rai_clr = 7;
  localparam int bit_f12_mode = 0;
  localparam int bit_esf_mode = 2;

  localparam logic [7:0] reset_byte = 8'h00;

  // ---------------------------------------------------------------
  // alarm criteria
  // ---------------------------------------------------------------
  localparam int ais_window_us = 3000;
  localparam int ais_set_zeros = 4;
  localparam int ais_clr_zeros = 5;
  localparam int rai_chan_span = 256;
  localparam int rai_chan_set = 254;
  localparam int fdl_span = 16;
  localparam int fdl_clr_max = 14;
  localparam logic [15:0] fdl_yellow = 16'h00ff;
  localparam int los_zero_run = 192;
  localparam int los_one_span = 112;
  localparam int los_one_need = 14;

endpackage : alarm_pkg

// ### test/alarm_chk_sva.sv
`timescale 1ns/1ps
module alarm_chk #(
  parameter logic [2:0] framer_num = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_frame_loss_now,
  input wire logic irq_out_n
);
  // ----------------------------------------
  // mask shadow, so irq checks know the enables
  // ----------------------------------------
  localparam logic [15:0] base = 16'(framer_num) * 16'h0800;
  wire logic [15:0] mask_a = base + 16'(alarm_pkg::ofs_rx_irq_mask_1) * 16'h0004;
  wire logic wr_any = psel && pwrite;
  wire logic wr_mask = wr_any && penable && pready && pstrb[0] &&
    paddr == mask_a;
  logic [7:0] mask_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= 8'h00;
    else if (wr_mask) mask_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready && penable)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_err_unaligned: assert property
    (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_err_stride: assert property (
    psel && !penable && paddr == base + 16'h0240 |=> !pslverr)
    else $error("own latched register refused");
  a_irq_lof_rise: assert property (
    $rose(rx_frame_loss_now) && mask_r[0] |-> ##[1:12] !irq_out_n)
    else $error("frame loss gave no interrupt");
  a_irq_lof_fall: assert property (
    $fell(rx_frame_loss_now) && mask_r[4] |-> ##[1:12] !irq_out_n)
    else $error("frame regain gave no interrupt");
  a_irq_sticky: assert property (
    !irq_out_n && !wr_any && !$past(wr_any) |=> !irq_out_n)
    else $error("interrupt released without a write");
  a_irq_masked: assert property (
    (mask_r == 8'h00) [*3] |-> irq_out_n)
    else $error("interrupt with all masks off");
endmodule : alarm_chk

bind t1_alarm_status_interrupt alarm_chk #(.framer_num(framer_num)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_frame_loss_now(rx_frame_loss_now), .irq_out_n(irq_out_n));

// ### test/apb_host.sv
`timescale 1ns/1ps
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'h1;
  end
  // one transfer; request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // read first, then write ones only where clearing is wanted
  task automatic clear(input logic [15:0] a, input logic [7:0] m);
    logic [7:0] q;
    logic e;
    xfer(1'b0, a, 8'h00, q, e);
    xfer(1'b1, a, q & m, q, e);
  endtask : clear
endmodule : apb_host

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, fdl_word = 16'h0000, seed = 16'h0011;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_frame_loss_now = 1'b0;
  logic chan_bit2_valid = 1'b0, chan_bit2 = 1'b0, fbit12_valid = 1'b0;
  logic fbit12 = 1'b0, fdl_word_valid = 1'b0, irq_out_n, e;
  logic [7:0] q;
  int error_cnt = 0, total_checks = 0, m_lat = 0, mq[$];
  logic [8:0] tbl[$] = '{alarm_pkg::ofs_rx_latched_status_1, alarm_pkg::ofs_rx_irq_mask_1,
    alarm_pkg::ofs_live1, alarm_pkg::ofs_rx_ctl2, alarm_pkg::ofs_lcv_hi,
    alarm_pkg::ofs_tx_sync_latched_status, alarm_pkg::ofs_rx_irq_mask_3};
  always #10 pclk = ~pclk;
  t1_alarm_status_interrupt #(.framer_num(3'h1), .ais_window_bits(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_frame_loss_now(rx_frame_loss_now),
    .chan_bit2_valid(chan_bit2_valid), .chan_bit2(chan_bit2),
    .fbit12_valid(fbit12_valid), .fbit12(fbit12),
    .fdl_word_valid(fdl_word_valid), .fdl_word(fdl_word),
    .irq_out_n(irq_out_n));
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] ad(input logic [8:0] o);
    return 16'h0800 + 16'(o) * 16'h0004;
  endfunction : ad
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [8:0] o, input logic [7:0] d);
    host.xfer(1'b1, ad(o), d, q, e);
  endtask : wr
  task automatic look(input logic [8:0] o, input logic [7:0] m,
    input logic [7:0] exp, input string what);
    host.xfer(1'b0, ad(o), 8'h00, q, e);
    chk({7'h00, e}, 8'h00, "pslverr");
    chk(q & m, exp, what);
  endtask : look
  task automatic irq(input logic exp);
    // pin moves by the third edge; look one edge later, once it has settled
    repeat (4) @(posedge pclk);
    chk({7'h00, irq_out_n}, {7'h00, exp}, "irq_out_n");
  endtask : irq
  // n line bits, every p-th one a zero (p = 0: all ones)
  task automatic bits(input int n, input int p);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_bit_valid <= 1'b1;
      rx_bit <= !(p > 0 && i % p == p - 1);
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask : bits
  // kind 0 channel bit 2, 1 twelfth f-bit, 2 data link word
  task automatic ev(input int n, input int kind, input logic [15:0] v);
    repeat (n) begin
      @(posedge pclk);
      chan_bit2_valid <= kind == 0;
      fbit12_valid <= kind == 1;
      fdl_word_valid <= kind == 2;
      {chan_bit2, fbit12, fdl_word} <= {v[0], v[0], v};
      @(posedge pclk);
      {chan_bit2_valid, fbit12_valid, fdl_word_valid} <= 3'b000;
    end
    repeat (4) @(posedge pclk);
  endtask : ev
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (tbl[i]) look(tbl[i], 8'hff, 8'h00, "reset value");
    host.xfer(1'b0, 16'h0240, 8'h00, q, e);
    chk({7'h00, e}, 8'h01, "other framer");
    host.xfer(1'b0, ad(alarm_pkg::ofs_rx_latched_status_1) + 16'h0001, 8'h00, q, e);
    chk({7'h00, e}, 8'h01, "unaligned");
    wr(alarm_pkg::ofs_live1, 8'hff);
    look(alarm_pkg::ofs_live1, 8'hff, 8'h00, "live read only");
    repeat (4) begin
      seed = lfsr(seed);
      wr(alarm_pkg::ofs_rx_irq_mask_1, seed[7:0]);
      mq.push_back(int'(seed[7:0]));
      look(alarm_pkg::ofs_rx_irq_mask_1, 8'hff, 8'(mq.pop_front()), "mask");
    end
    $display("register map test done");
    wr(alarm_pkg::ofs_rx_irq_mask_1, 8'h11);
    rx_frame_loss_now <= 1'b1;
    irq(1'b0);
    look(alarm_pkg::ofs_live1, 8'h01, 8'h01, "live lof");
    look(alarm_pkg::ofs_rx_latched_status_1, 8'hff, 8'h01, "lof seen");
    wr(alarm_pkg::ofs_rx_latched_status_1, 8'h00);
    look(alarm_pkg::ofs_rx_latched_status_1, 8'hff, 8'h01, "write zero");
    wr(alarm_pkg::ofs_rx_latched_status_1, 8'h01);
    irq(1'b1);
    repeat (10) @(posedge pclk);
    look(alarm_pkg::ofs_rx_latched_status_1, 8'hff, 8'h00, "no reset");
    rx_frame_loss_now <= 1'b0;
    irq(1'b0);
    look(alarm_pkg::ofs_rx_latched_status_1, 8'hff, 8'h10, "regained");
    host.clear(ad(alarm_pkg::ofs_rx_latched_status_1), 8'h10);
    irq(1'b1);
    $display("frame loss test done");
    bits(191, 1);
    look(alarm_pkg::ofs_live1, 8'h02, 8'h00, "los 191");
    bits(1, 1);
    look(alarm_pkg::ofs_live1, 8'h02, 8'h02, "los 192");
    bits(13, 0);
    bits(99, 1);
    look(alarm_pkg::ofs_live1, 8'h02, 8'h02, "los 13 ones");
    bits(14, 0);
    look(alarm_pkg::ofs_live1, 8'h02, 8'h00, "los 14 ones");
    bits(40, 4);
    look(alarm_pkg::ofs_live1, 8'h04, 8'h00, "blue 5 zeros");
    // blue is an unframed signal, so the host sees it with frame loss
    rx_frame_loss_now <= 1'b1;
    bits(40, 5);
    look(alarm_pkg::ofs_live1, 8'h05, 8'h05, "blue 4 zeros");
    rx_frame_loss_now <= 1'b0;
    bits(40, 4);
    look(alarm_pkg::ofs_live1, 8'h04, 8'h00, "blue 5 zeros");
    $display("line alarm test done");
    ev(254, 0, 16'h0000);
    ev(2, 0, 16'h0001);
    look(alarm_pkg::ofs_live1, 8'h08, 8'h08, "bit2 254");
    ev(253, 0, 16'h0000);
    ev(3, 0, 16'h0001);
    look(alarm_pkg::ofs_live1, 8'h08, 8'h00, "bit2 253");
    wr(alarm_pkg::ofs_rx_ctl2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      ev(1, 1, {15'h0000, i < 2});
      look(alarm_pkg::ofs_live1, 8'h08, {4'h0, i[0] ^ i[1], 3'h0},
        "f12 yellow");
    end
    wr(alarm_pkg::ofs_rx_ctl2, 8'h04);
    ev(16, 2, alarm_pkg::fdl_yellow);
    look(alarm_pkg::ofs_live1, 8'h08, 8'h08, "esf 16");
    seed = lfsr(seed);
    ev(15, 2, alarm_pkg::fdl_yellow);
    ev(1, 2, seed | 16'h0100);
    look(alarm_pkg::ofs_live1, 8'h08, 8'h08, "esf 15");
    ev(14, 2, alarm_pkg::fdl_yellow);
    ev(2, 2, seed | 16'h0100);
    look(alarm_pkg::ofs_live1, 8'h08, 8'h00, "esf 14");
    $display("yellow alarm test done");
    // every live bit rose and fell since the last clear
    m_lat = 'hff;
    look(alarm_pkg::ofs_rx_latched_status_1, 8'hff, 8'(m_lat), "edges");
    wr(alarm_pkg::ofs_rx_irq_mask_1, 8'hff);
    irq(1'b0);
    host.clear(ad(alarm_pkg::ofs_rx_latched_status_1), 8'hff);
    irq(1'b1);
    $display("latched status test done");
    close_out();
  end
endmodule : testbench
